// ==== pkg/lin_seq_map.vh ====
// register offsets, field positions, reset values and timing for the lin/uart sequencer
`ifndef LIN_SEQ_MAP_VH
`define LIN_SEQ_MAP_VH
// register indices (byte address = index * 1 on this plain port)
`define OFS_CONTROL     8'h00
`define OFS_STATUS      8'h01
`define OFS_ERROR       8'h02
`define OFS_BAUD        8'h03
`define OFS_LENGTH      8'h04
`define OFS_IDENT       8'h05
`define OFS_BUFSEL      8'h06
`define OFS_DATA        8'h07
// control register fields
`define CTL_CMD_LSB     0
`define CTL_ENA_BIT     4
`define CTL_LEGACY_BIT  5
// status register fields
`define ST_RX_DONE      0
`define ST_TX_DONE      1
`define ST_ERR          2
`define ST_ID_OK        3
`define ST_BUSY         4
// error register fields
`define ER_PARITY       0
`define ER_CHECKSUM     1
`define ER_FRAMING      2
`define ER_BIT          3
`define ER_OVERRUN      4
`define ER_TIMEOUT      5
`define ER_ABORT        6
// reset values
`define RST_IDENT       8'h80
`define RST_BAUD        12'h01f
// protocol constants
`define SYNC_CHAR       8'h55
`define BREAK_BITS      5'd13
`define BREAK_MIN       5'd11
`define TIMEOUT_BITS    12'd180
`endif

// ==== logic/lin_uart_command_sequencer.v ====
// lin/uart command sequencer with header, response and byte services
// Operation
// - enable cleared disables controller immediately
// - lin command bits select four functions
// - top command bit picks lin or uart
// - uart bits enable receive and/or transmit
// - uart: no checksum, timeout, lengths zero
// - clearing low bits aborts, sets abort flag
// - rx header: break, sync, id, timeout
// - legacy: length loaded from identifier after header
// - tx header: 13-bit break, 0x55, identifier
// - after header: flags, timeout, command 00
// - checksum kind sampled at response start
// - response done: flags, command 00
// - lin error stops response, line recessive
// - new header recorded during response, errors kept
// - lin data via fifo, buffer select indexed
// - uart data port is plain register
// - rx char sets done; read clears it
// - two-stage receive buffer, overrun flagged
// - framing error flagged on bad stop
// - tx write starts char, clears done
// - protocol bit 0 enhanced (classic for ids 0x3c-0x3f), 1 classic
// - four lin events raised
//
// Our own choices: the register offsets and the strobed register port.
`include "lin_seq_map.vh"
`default_nettype none
module lin_uart_command_sequencer #(
  parameter SAMPLES = 16   // clock enables per bit
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_n,
  // register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata_q,
  // serial line
  input  wire       rx_pin,
  output reg        tx_pin_q
);
  // states, one-hot
  localparam [4:0] S_IDLE = 5'h01, S_BRK = 5'h02, S_BYTE = 5'h04, S_WAIT = 5'h08, S_STOP = 5'h10;
  // software registers
  reg [2:0]  command_field_q;  // command bits
  reg        controller_enable_q;
  reg        legacy_protocol_select_q;
  reg [11:0] baud_divider_q;
  reg [7:0]  identifier_q;
  reg [3:0]  rx_length_field_q, tx_length_field_q;
  reg [2:0]  buf_sel_q;
  reg [7:0]  error_q;
  reg        rx_done_flag_q, tx_done_flag_q, id_ready_flag_q;
  reg [7:0]  fifo_q [0:7];   // response data buffer
  reg [7:0]  uart_hold_q;    // second receive stage
  reg        hold_full_q, hold_ovr_q;
  reg        lin_err;         // one-cycle lin error pulse
  reg        utx_pend_q;      // uart character waiting to go
  reg [7:0]  utx_q;
  // synchroniser
  reg rx_m_q, rx_s_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      rx_m_q <= rx_pin;
      rx_s_q <= rx_m_q;
    end
  end
  // baud tick divider
  reg [11:0] div_q;
  reg        tick_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 12'h000;
      tick_q <= 1'b0;
    end else if (div_q >= baud_divider_q) begin
      div_q  <= 12'h000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 12'h001;
      tick_q <= 1'b0;
    end
  end
  wire lin_mode  = controller_enable_q & ~command_field_q[2];
  wire uart_mode = controller_enable_q &  command_field_q[2];
  wire uart_rx_en = uart_mode & command_field_q[1];
  wire uart_tx_en = uart_mode & command_field_q[0];
  wire cmd_txh = lin_mode & (command_field_q[1:0] == 2'b01);
  wire cmd_rxr = lin_mode & (command_field_q[1:0] == 2'b10);
  wire cmd_txr = lin_mode & (command_field_q[1:0] == 2'b11);
  wire wr_ctl  = wr && addr == `OFS_CONTROL;
  wire wr_data = wr && addr == `OFS_DATA;
  wire rd_data = rd && addr == `OFS_DATA;
  wire abort   = wr_ctl && lin_mode && wdata[`CTL_ENA_BIT] && !wdata[2]
                 && wdata[1:0] == 2'b00 && command_field_q[1:0] != 2'b00;
  // ---------------- receiver: bit sampler, shared by lin and uart ----------------
  reg [4:0]  rs_st_q;
  reg [7:0]  rs_cnt_q;    // sub-bit count
  reg [3:0]  rs_bit_q;
  reg [7:0]  rs_sh_q;
  reg [4:0]  low_q;       // consecutive low bits for break
  reg        rx_byte_p, rx_framing_error_p;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_st_q <= S_IDLE; rs_cnt_q <= 8'h00; rs_bit_q <= 4'h0; rs_sh_q <= 8'h00;
      low_q <= 5'd0; rx_byte_p <= 1'b0; rx_framing_error_p <= 1'b0;
    end else begin
      rx_byte_p <= 1'b0;
      rx_framing_error_p <= 1'b0;
      if (!controller_enable_q) begin
        rs_st_q <= S_IDLE;
        low_q   <= 5'd0;
      end else if (tick_q) begin
        case (rs_st_q)
          S_IDLE: begin
            if (!rx_s_q) begin
              rs_st_q <= S_BYTE; rs_cnt_q <= 8'h00; rs_bit_q <= 4'h0;
            end
          end
          S_BYTE: begin
            if (rs_cnt_q == SAMPLES[7:0] + (SAMPLES[7:0] >> 1) - 8'h01 ||
                (rs_bit_q != 4'h0 && rs_cnt_q == SAMPLES[7:0] - 8'h01)) begin
              rs_cnt_q <= 8'h00;
              rs_sh_q  <= {rx_s_q, rs_sh_q[7:1]};  // lsb first
              rs_bit_q <= rs_bit_q + 4'h1;
              if (rs_bit_q == 4'h7) rs_st_q <= S_STOP;
            end else rs_cnt_q <= rs_cnt_q + 8'h01;
          end
          S_STOP: begin
            if (rs_cnt_q == SAMPLES[7:0] - 8'h01) begin
              rs_cnt_q <= 8'h00;
              rx_byte_p <= rx_s_q;
              rx_framing_error_p <= ~rx_s_q;
              low_q <= (!rx_s_q && rs_sh_q == 8'h00) ? 5'd10 : 5'd0;
              rs_st_q <= rx_s_q ? S_IDLE : S_WAIT;
            end else rs_cnt_q <= rs_cnt_q + 8'h01;
          end
          S_WAIT: begin
            // line stays low: break candidate, wait for release
            if (rx_s_q) rs_st_q <= S_IDLE;
          end
          default: rs_st_q <= S_IDLE;
        endcase
      end
    end
  end
  wire brk_seen = tick_q && rs_st_q == S_WAIT && rx_s_q && low_q >= `BREAK_MIN - 5'd1;
  // ---------------- transmitter: shared serialiser ----------------
  reg [4:0] ts_st_q;
  reg [7:0] ts_cnt_q;
  reg [4:0] ts_bit_q;
  reg [9:0] ts_sh_q;
  reg       ts_go;          // start a byte (comb)
  reg [7:0] ts_byte;
  reg       ts_brk;         // send a break instead
  wire      ts_idle = ts_st_q == S_IDLE;
  wire      bit_end = tick_q && ts_cnt_q == SAMPLES[7:0] - 8'h01;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ts_st_q <= S_IDLE; ts_cnt_q <= 8'h00; ts_bit_q <= 5'd0; ts_sh_q <= 10'h3ff;
      tx_pin_q <= 1'b1;
    end else if (!controller_enable_q || lin_err || abort) begin
      ts_st_q  <= S_IDLE;
      tx_pin_q <= 1'b1;
    end else begin
      case (ts_st_q)
        S_IDLE: begin
          tx_pin_q <= 1'b1;
          if (ts_go && tick_q) begin   // start on a tick: first bit full length
            ts_st_q  <= S_BYTE; ts_cnt_q <= 8'h00;
            ts_bit_q <= ts_brk ? `BREAK_BITS + 5'd1 : 5'd10;
            ts_sh_q  <= ts_brk ? 10'h000 : {1'b1, ts_byte, 1'b0};
          end
        end
        S_BYTE: begin
          tx_pin_q <= ts_sh_q[0] | (ts_bit_q == 5'd1);   // break ends with one stop
          if (bit_end) begin
            ts_cnt_q <= 8'h00;
            ts_sh_q  <= {ts_sh_q[9], ts_sh_q[9:1]};  // break stays low, byte fills high
            ts_bit_q <= ts_bit_q - 5'd1;
            if (ts_bit_q == 5'd1) ts_st_q <= S_IDLE;
          end else if (tick_q) ts_cnt_q <= ts_cnt_q + 8'h01;
        end
        default: ts_st_q <= S_IDLE;
      endcase
    end
  end
  wire ts_done = ts_st_q == S_BYTE && bit_end && ts_bit_q == 5'd1;
  // ---------------- lin frame sequencer ----------------
  localparam [4:0] F_IDLE = 5'h01, F_SYNC = 5'h02, F_ID = 5'h04, F_DATA = 5'h08, F_CSUM = 5'h10;
  reg [4:0]  fr_q;            // receive-header / header-tx progress
  reg [4:0]  rsp_q;           // response progress
  reg [3:0]  rsp_n_q;         // bytes handled
  reg [8:0]  csum_q;
  reg        enh_q;           // enhanced checksum latched at start
  reg [11:0] to_q;            // frame timeout, in bit times while transmitting, in ticks while the transmitter idles
  reg        to_run_q;
  reg [2:0]  acc_q;           // fifo index for software accesses
  reg [7:0]  tx_sel;
  wire [7:0] id_in = rs_sh_q;
  wire       par_ok = (id_in[6] == (id_in[0]^id_in[1]^id_in[2]^id_in[4])) &&
                      (id_in[7] == ~(id_in[1]^id_in[3]^id_in[4]^id_in[5]));
  wire [3:0] legacy_len = identifier_q[5] ? (identifier_q[4] ? 4'd8 : 4'd4)
                                          : 4'd2;
  wire [3:0] rsp_len = cmd_txr ? tx_length_field_q : rx_length_field_q;
  wire [8:0] csum_add = {1'b0, csum_q[7:0]} + {1'b0, tx_sel} + {8'h00, csum_q[8]};
  wire [8:0] csum_rx  = {1'b0, csum_q[7:0]} + {1'b0, rs_sh_q} + {8'h00, csum_q[8]};
  // combinational transmit source selection
  always @* begin
    ts_go = 1'b0; ts_brk = 1'b0; ts_byte = 8'h00;
    tx_sel = fifo_q[rsp_n_q[2:0]];
    if (ts_idle && cmd_txh && fr_q == F_IDLE) begin
      ts_go = 1'b1; ts_brk = 1'b1;
    end else if (ts_idle && cmd_txh && fr_q == F_SYNC) begin
      ts_go = 1'b1; ts_byte = `SYNC_CHAR;
    end else if (ts_idle && cmd_txh && fr_q == F_ID) begin
      ts_go = 1'b1; ts_byte = identifier_q;
    end else if (ts_idle && cmd_txr && rsp_q == F_DATA) begin
      ts_go = 1'b1; ts_byte = tx_sel;
    end else if (ts_idle && cmd_txr && rsp_q == F_CSUM) begin
      ts_go = 1'b1; ts_byte = ~(csum_q[7:0] + {7'h00, csum_q[8]});
    end else if (ts_idle && uart_tx_en && utx_pend_q) begin
      ts_go = 1'b1; ts_byte = utx_q;
    end
  end
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_q <= F_IDLE; rsp_q <= F_IDLE; rsp_n_q <= 4'h0; csum_q <= 9'h000; enh_q <= 1'b0;
      to_q <= 12'h000; to_run_q <= 1'b0; lin_err <= 1'b0;
      id_ready_flag_q <= 1'b0; rx_done_flag_q <= 1'b0; tx_done_flag_q <= 1'b0;
      error_q <= 8'h00; identifier_q <= `RST_IDENT; command_field_q <= 3'b000;
      controller_enable_q <= 1'b0; legacy_protocol_select_q <= 1'b0;
      baud_divider_q <= `RST_BAUD; rx_length_field_q <= 4'h0; tx_length_field_q <= 4'h0;
      buf_sel_q <= 3'h0; acc_q <= 3'h0; uart_hold_q <= 8'h00; hold_full_q <= 1'b0;
      hold_ovr_q <= 1'b0; utx_pend_q <= 1'b0; utx_q <= 8'h00; rdata_q <= 8'h00;
    end else begin
      lin_err <= 1'b0;
      // register writes
      if (wr_ctl) begin
        controller_enable_q      <= wdata[`CTL_ENA_BIT];
        command_field_q          <= wdata[2:0];
        legacy_protocol_select_q <= wdata[`CTL_LEGACY_BIT];
      end
      if (wr && addr == `OFS_BAUD)  baud_divider_q <= {4'h0, wdata};
      if (wr && addr == `OFS_IDENT) identifier_q <= wdata;
      if (wr && addr == `OFS_LENGTH && !uart_mode) begin
        rx_length_field_q <= wdata[3:0];
        tx_length_field_q <= wdata[7:4];
      end
      if (wr && addr == `OFS_BUFSEL) begin
        buf_sel_q <= wdata[2:0];
        acc_q     <= wdata[2:0];
      end
      if (wr && addr == `OFS_STATUS) begin   // write one to clear
        if (wdata[`ST_RX_DONE]) rx_done_flag_q <= 1'b0;
        if (wdata[`ST_TX_DONE]) tx_done_flag_q <= 1'b0;
        if (wdata[`ST_ID_OK])   id_ready_flag_q <= 1'b0;
        if (wdata[`ST_ERR])     error_q <= 8'h00;
      end
      if (uart_mode) begin
        rx_length_field_q <= 4'h0;
        tx_length_field_q <= 4'h0;
      end
      // data port
      if (wr_data) begin
        if (uart_mode) begin
          if (uart_tx_en) begin
            utx_q <= wdata; utx_pend_q <= 1'b1; tx_done_flag_q <= 1'b0;
          end
        end else begin
          fifo_q[acc_q] <= wdata;
          acc_q <= acc_q + 3'h1;
        end
      end
      if (rd_data) begin
        if (uart_mode) begin
          rdata_q <= uart_hold_q;
          rx_done_flag_q <= 1'b0;
          hold_full_q <= 1'b0;
          if (hold_ovr_q) error_q[`ER_OVERRUN] <= 1'b1;
          hold_ovr_q <= 1'b0;
        end else begin
          rdata_q <= fifo_q[acc_q];
          acc_q <= acc_q + 3'h1;
        end
      end else if (rd) begin
        case (addr)
          `OFS_CONTROL: rdata_q <= {2'b00, legacy_protocol_select_q, controller_enable_q,
                                    1'b0, command_field_q};
          `OFS_STATUS:  rdata_q <= {3'b000, ~ts_idle, id_ready_flag_q, |error_q,
                                    tx_done_flag_q, rx_done_flag_q};
          `OFS_ERROR:   rdata_q <= error_q;
          `OFS_BAUD:    rdata_q <= baud_divider_q[7:0];
          `OFS_LENGTH:  rdata_q <= {tx_length_field_q, rx_length_field_q};
          `OFS_IDENT:   rdata_q <= identifier_q;
          `OFS_BUFSEL:  rdata_q <= {5'h00, buf_sel_q};
          default:      rdata_q <= 8'h00;
        endcase
      end
      if (ts_go && tick_q && utx_pend_q && uart_tx_en) utx_pend_q <= 1'b0;
      if (ts_done && uart_tx_en) tx_done_flag_q <= 1'b1;
      // uart receive into holding stage
      if (uart_rx_en && rx_byte_p) begin
        uart_hold_q <= rs_sh_q;
        hold_ovr_q  <= hold_full_q && !rd_data;
        hold_full_q <= 1'b1;
        rx_done_flag_q <= 1'b1;
      end
      if (uart_rx_en && rx_framing_error_p) error_q[`ER_FRAMING] <= 1'b1;
      // frame timeout, lin only
      if (to_run_q && tick_q && lin_mode) begin
        if (ts_cnt_q == 8'h00) to_q <= to_q + 12'h001;
        if (to_q >= `TIMEOUT_BITS && rsp_q != F_IDLE) begin
          error_q[`ER_TIMEOUT] <= 1'b1; lin_err <= 1'b1;
          rsp_q <= F_IDLE; to_run_q <= 1'b0;
        end
      end
      // header reception in background
      if (lin_mode && !cmd_txh) begin
        if (brk_seen) fr_q <= F_SYNC;
        else if (rx_byte_p && fr_q == F_SYNC)
          fr_q <= (rs_sh_q == `SYNC_CHAR) ? F_ID : F_IDLE;
        else if (rx_byte_p && fr_q == F_ID) begin
          fr_q <= F_IDLE;
          identifier_q <= rs_sh_q;
          id_ready_flag_q <= 1'b1;
          to_q <= 12'h000; to_run_q <= 1'b1;
          if (!par_ok) error_q[`ER_PARITY] <= 1'b1;
          if (legacy_protocol_select_q) begin
            rx_length_field_q <= legacy_len;
            tx_length_field_q <= legacy_len;
          end
        end
      end
      // header transmission steps
      if (cmd_txh && ts_done) begin
        case (fr_q)
          F_IDLE: fr_q <= F_SYNC;
          F_SYNC: fr_q <= F_ID;
          F_ID: begin
            fr_q <= F_IDLE;
            command_field_q[1:0] <= 2'b00;
            id_ready_flag_q <= 1'b1;
            to_q <= 12'h000; to_run_q <= 1'b1;
            if (legacy_protocol_select_q) begin
              rx_length_field_q <= legacy_len;
              tx_length_field_q <= legacy_len;
            end
          end
          default: fr_q <= F_IDLE;
        endcase
      end
      // response start: latch checksum kind
      if ((cmd_rxr || cmd_txr) && rsp_q == F_IDLE && !rsp_n_q[3]) begin
        enh_q   <= !legacy_protocol_select_q && identifier_q[5:2] != 4'hf;
        csum_q  <= (!legacy_protocol_select_q && identifier_q[5:2] != 4'hf)
                   ? {1'b0, identifier_q} : 9'h000;
        rsp_n_q <= 4'h8;  // marks started
        rsp_q   <= (rsp_len == 4'h0) ? F_CSUM : F_DATA;
      end else if (rsp_q == F_DATA && ((cmd_txr && ts_done) || (cmd_rxr && rx_byte_p))) begin
        csum_q <= cmd_txr ? csum_add : csum_rx;
        if (cmd_rxr) fifo_q[rsp_n_q[2:0]] <= rs_sh_q;
        rsp_n_q <= {1'b1, rsp_n_q[2:0] + 3'h1};
        if ({1'b0, rsp_n_q[2:0]} + 4'h1 == rsp_len) rsp_q <= F_CSUM;
      end else if (rsp_q == F_CSUM && ((cmd_txr && ts_done) || (cmd_rxr && rx_byte_p))) begin
        rsp_q <= F_IDLE; rsp_n_q <= 4'h0; to_run_q <= 1'b0;
        command_field_q[1:0] <= 2'b00;
        if (cmd_txr) tx_done_flag_q <= 1'b1;
        else if (csum_rx[7:0] + {7'h00, csum_rx[8]} != 8'hff) begin
          error_q[`ER_CHECKSUM] <= 1'b1; lin_err <= 1'b1;
        end else rx_done_flag_q <= 1'b1;
      end
      if (rsp_q != F_IDLE && (rx_framing_error_p || (cmd_txr && ts_st_q == S_BYTE && bit_end &&
          rx_s_q != tx_pin_q))) begin
        error_q[`ER_BIT] <= 1'b1; lin_err <= 1'b1;
        rsp_q <= F_IDLE; rsp_n_q <= 4'h0;
      end
      // abort and disable
      if (abort) begin
        error_q[`ER_ABORT] <= 1'b1;
        rsp_q <= F_IDLE; rsp_n_q <= 4'h0; fr_q <= F_IDLE;
      end
      if (!controller_enable_q) begin
        rsp_q <= F_IDLE; rsp_n_q <= 4'h0; fr_q <= F_IDLE; to_run_q <= 1'b0;
        utx_pend_q <= 1'b0;
      end
    end
  end
endmodule // lin_uart_command_sequencer
`default_nettype wire

// ==== testbench/seq_checker_assertions.sv ====
// port checker for the lin/uart command sequencer
`include "lin_seq_map.vh"
`default_nettype none
module seq_checker #(
  parameter int SAMPLES = 16  // clock enables per bit
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata_q,
  // serial line
  input wire logic       rx_pin,
  input wire logic       tx_pin_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  div_q;   // baud divider shadow
  logic [15:0] low_q;   // clocks of the current low run
  logic        uart_q;  // uart mode chosen
  logic        utx_q;   // uart transmit enabled
  wire  [15:0] bit_w = (16'(div_q) + 16'h1) * 16'(SAMPLES);  // clocks per bit
  wire         ctl_w = wr && addr == `OFS_CONTROL;            // control write
  // track divider, mode and low run of the line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 8'(`RST_BAUD);
      low_q  <= 16'h0;
      uart_q <= 1'b0;
      utx_q  <= 1'b0;
    end else begin
      low_q <= tx_pin_q ? 16'h0 : low_q + 16'h1;
      if (wr && addr == `OFS_BAUD) begin
        div_q <= wdata;
      end
      if (ctl_w) begin
        uart_q <= wdata[4] & wdata[2];
        utx_q  <= wdata[4] & wdata[2] & wdata[0];
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rst_idle; $rose(rst_n) |-> tx_pin_q; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("line busy after reset");
  property p_off_idle; ctl_w && !wdata[4] |-> ##[1:2] tx_pin_q [*8]; endproperty
  a_off_idle: assert property (p_off_idle) else $error("line busy after disable");
  property p_abort_idle;
    ctl_w && wdata[4] && wdata[2:0] == 3'b000 |-> ##[1:2] (tx_pin_q && $stable(tx_pin_q)) [*6];
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("line busy after abort");
  property p_break_len; $rose(tx_pin_q) |-> low_q <= 16'd13 * bit_w; endproperty
  a_break_len: assert property (p_break_len) else $error("low run too long");
  property p_unmapped; rd && addr > `OFS_DATA |=> rdata_q == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_uart_len; rd && addr == `OFS_LENGTH && uart_q |=> rdata_q == 8'h00; endproperty
  a_uart_len: assert property (p_uart_len) else $error("length not zero in uart");
  property p_tx_start; wr && addr == `OFS_DATA && utx_q |-> ##[1:40] !tx_pin_q; endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit after write");
  property p_rdata_hold; !rd |=> $stable(rdata_q); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_off_read;
    (ctl_w && wdata == 8'h00) ##[1:2] (rd && addr == `OFS_CONTROL) |=> rdata_q == 8'h00;
  endproperty
  a_off_read: assert property (p_off_read) else $error("control not cleared");
  c_header: cover property (ctl_w && wdata[2:0] == 3'b001);
  c_break: cover property ($rose(tx_pin_q) && low_q == 16'd13 * bit_w);
  c_uart_rx: cover property (rd && addr == `OFS_DATA && uart_q && !utx_q);
endmodule  // seq_checker
bind lin_uart_command_sequencer seq_checker #(.SAMPLES(SAMPLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_q(rdata_q), .rx_pin(rx_pin), .tx_pin_q(tx_pin_q)
);
`default_nettype wire

// ==== testbench/lin_peer.sv ====
// far-side node model: serial peer on the shared line
`default_nettype none
module lin_peer #(
  parameter int BIT = 8  // clocks per bit
) (
  // clock
  input  wire logic ref_clk,
  // shared line and this node's pull-down
  input  wire logic line,
  output var  logic drive
);
  timeunit 1ns;
  timeprecision 1ps;
  initial drive = 1'b1;  // released, pull-up holds recessive
  // send one character lsb first with a chosen stop level
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      drive <= f[i];
      repeat (BIT - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    drive <= 1'b1;
    repeat (BIT) @(posedge ref_clk);
  endtask
  // take one character off the line, mid-bit sampling
  task automatic grab(output logic [7:0] b);
    while (line !== 1'b0) @(posedge ref_clk);
    repeat (BIT + BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = line;
      repeat (BIT) @(posedge ref_clk);
    end
  endtask
  // clocks of the next low run
  task automatic measure(output int n);
    n = 0;
    while (line !== 1'b0) @(posedge ref_clk);
    while (line === 1'b0) begin
      n++;
      @(posedge ref_clk);
    end
  endtask
endmodule  // lin_peer
`default_nettype wire

// ==== testbench/lin_uart_command_sequencer_bench.sv ====
// self-checking bench for the lin/uart command sequencer
`include "lin_seq_map.vh"
`default_nettype none
module lin_uart_command_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 8;     // divider 1, four samples
  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  wire  [7:0] rdata_q;
  wire        tx_pin;
  wire        drive;
  wire        line = tx_pin & drive;  // wired-and bus
  int         failures = 0;
  int         compares = 0;
  int         cycles   = 0;
  always #2 ref_clk = ~ref_clk;
  lin_uart_command_sequencer #(.SAMPLES(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .rx_pin(line),
    .tx_pin_q(tx_pin));
  lin_peer #(.BIT(BIT)) peer (.ref_clk(ref_clk), .line(line), .drive(drive));
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata_q;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic t_reset;
    logic [7:0] v;
    chk("line idle", 8'h01, {7'h0, tx_pin});
    rd_reg(`OFS_IDENT, v);
    chk("ident reset", `RST_IDENT, v);
    rd_reg(`OFS_BAUD, v);
    chk("baud reset", 8'(`RST_BAUD), v);
    rd_reg(8'h3a, v);
    chk("unmapped", 8'h00, v);
    wr_reg(`OFS_BAUD, 8'h01);
  endtask
  task automatic t_header;
    logic [7:0] v;
    logic [7:0] idv;
    int         n;
    wr_reg(`OFS_IDENT, 8'h30);
    rd_reg(`OFS_IDENT, idv);
    wr_reg(`OFS_CONTROL, 8'h31);  // legacy, enabled, send header
    peer.measure(n);
    chk("break clocks", 8'(13 * BIT), 8'(n));
    peer.grab(v);
    chk("sync char", `SYNC_CHAR, v);
    peer.grab(v);
    chk("ident sent", idv, v);
    repeat (3 * BIT) @(posedge ref_clk);
    rd_reg(`OFS_CONTROL, v);
    chk("command after header", 8'h30, v);
    rd_reg(`OFS_STATUS, v);
    chk("id ready", 8'h01, {7'h0, v[`ST_ID_OK]});
    n = (idv[5:4] < 2'd2) ? 2 : ((idv[5:4] == 2'd2) ? 4 : 8);
    rd_reg(`OFS_LENGTH, v);
    chk("legacy length", {2{4'(n)}}, v);
  endtask
  // one-byte lin responses after the header, id 0x30, enhanced checksum
  task automatic t_response;
    logic [7:0] v;
    wr_reg(`OFS_DATA, 8'h5a);
    wr_reg(`OFS_LENGTH, 8'h11);
    wr_reg(`OFS_CONTROL, 8'h13);  // current protocol, send response
    peer.grab(v);
    chk("response data", 8'h5a, v);
    peer.grab(v);
    chk("checksum sent", 8'h75, v);
    repeat (3 * BIT) @(posedge ref_clk);
    rd_reg(`OFS_STATUS, v);
    chk("tx response done", 8'h01, {7'h0, v[`ST_TX_DONE]});
    wr_reg(`OFS_CONTROL, 8'h12);
    peer.send(8'ha5, 1'b1);
    peer.send(8'h2a, 1'b1);  // inverted sum of 0x30 and 0xa5
    rd_reg(`OFS_STATUS, v);
    chk("rx response done", 8'h01, {7'h0, v[`ST_RX_DONE]});
    rd_reg(`OFS_CONTROL, v);
    chk("command after response", 8'h10, v);
    wr_reg(`OFS_BUFSEL, 8'h00);
    rd_reg(`OFS_DATA, v);
    chk("response stored", 8'ha5, v);
    wr_reg(`OFS_STATUS, 8'h01);
  endtask
  // cut a running header by abort or by disable
  task automatic t_kill(input logic [7:0] ctl, input logic abort);
    logic [7:0] v;
    wr_reg(`OFS_CONTROL, 8'h11);
    repeat (20) @(posedge ref_clk);
    chk("break running", 8'h00, {7'h0, tx_pin});
    wr_reg(`OFS_CONTROL, ctl);
    rd_reg(`OFS_CONTROL, v);
    chk("control after stop", ctl, v);
    chk("line released", 8'h01, {7'h0, tx_pin});
    if (abort) begin
      rd_reg(`OFS_ERROR, v);
      chk("abort flag", 8'h01, {7'h0, v[`ER_ABORT]});
    end
    wr_reg(`OFS_STATUS, 8'h04);
  endtask
  task automatic t_uart_rx;
    logic [7:0] v;
    wr_reg(`OFS_CONTROL, 8'h16);  // uart receive only
    peer.send(8'h3c, 1'b1);
    rd_reg(`OFS_STATUS, v);
    chk("rx done set", 8'h01, {7'h0, v[`ST_RX_DONE]});
    rd_reg(`OFS_DATA, v);
    chk("rx char", 8'h3c, v);
    rd_reg(`OFS_STATUS, v);
    chk("rx done cleared", 8'h00, {7'h0, v[`ST_RX_DONE]});
    peer.send(8'ha1, 1'b1);
    peer.send(8'h5a, 1'b1);
    peer.send(8'hc3, 1'b1);
    rd_reg(`OFS_DATA, v);
    chk("overwritten char", 8'hc3, v);
    rd_reg(`OFS_ERROR, v);
    chk("overrun flag", 8'h01, {7'h0, v[`ER_OVERRUN]});
    wr_reg(`OFS_STATUS, 8'h04);
    peer.send(8'h77, 1'b0);
    rd_reg(`OFS_ERROR, v);
    chk("framing flag", 8'h01, {7'h0, v[`ER_FRAMING]});
  endtask
  task automatic t_uart_tx;
    logic [7:0] v;
    logic [7:0] b;
    wr_reg(`OFS_CONTROL, 8'h15);  // uart transmit only
    wr_reg(`OFS_LENGTH, 8'h33);
    rd_reg(`OFS_LENGTH, v);
    chk("length in uart", 8'h00, v);
    wr_reg(`OFS_DATA, 8'ha5);
    fork
      peer.grab(b);
      begin
        rd_reg(`OFS_STATUS, v);
        chk("tx done cleared", 8'h00, {7'h0, v[`ST_TX_DONE]});
      end
    join
    chk("tx char", 8'ha5, b);
    repeat (2 * BIT) @(posedge ref_clk);
    rd_reg(`OFS_STATUS, v);
    chk("tx done set", 8'h01, {7'h0, v[`ST_TX_DONE]});
  endtask
  // cycle ceiling against a hang
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_header();
    t_response();
    t_kill(8'h10, 1'b1);
    t_kill(8'h00, 1'b0);
    t_uart_rx();
    t_uart_tx();
    wrap_up();
  end
endmodule  // lin_uart_command_sequencer_bench
`default_nettype wire
